// ---- design/rsm_clock_watch.sv ----
// Purpose: one-shot timer retriggered by every edge of the watched clock
// Assumes: watched clock level arrives synchronised to sys_clk
// Notes: missing is a one-cycle pulse when the timeout is reached
module rsm_clock_watch #(
  parameter logic [rsm_pkg::CNT_W-1:0] TIMEOUT_CYC = 16'h0010
) (
  // clock and reset
  input wire logic sys_clk,
  input wire logic reset,
  // control side
  rsm_mcd_if.watch mcd
);
  import rsm_pkg::*;

  logic lastLvl_r;
  logic [CNT_W-1:0] cnt_r;
  logic missing_r;
  logic edgeSeen;

  // any change of level retriggers the one-shot
  assign edgeSeen = mcd.clkLevel != lastLvl_r;

  // previous level for edge detection
  always_ff @(posedge sys_clk or posedge reset) begin
    if (reset) begin
      lastLvl_r <= 1'h0;
    end else begin
      lastLvl_r <= mcd.clkLevel;
    end
  end

  // time since last edge, stuck high or low both count
  always_ff @(posedge sys_clk or posedge reset) begin
    if (reset) begin
      cnt_r <= '0;
    end else if (!mcd.enable || edgeSeen) begin
      cnt_r <= '0;
    end else if (cnt_r != TIMEOUT_CYC) begin
      cnt_r <= cnt_r + CNT_W'(1);
    end
  end

  // single pulse on reaching the timeout, saturation stops repeats
  always_ff @(posedge sys_clk or posedge reset) begin
    if (reset) begin
      missing_r <= 1'h0;
    end else begin
      missing_r <= mcd.enable && !edgeSeen &&
        (cnt_r == TIMEOUT_CYC - CNT_W'(1));
    end
  end

  assign mcd.missing = missing_r;
endmodule : rsm_clock_watch

// ---- design/rsm_top.sv ----
// Purpose: reset source gathering, cause flags and supply monitor control
// Assumes: reset is the power-on reset; all sources are asynchronous
// Notes: sysReset holds the core; the reset pin is open-drain
//
// Added by the designer: the APB register port.

// Summary of operation
// - low supply drives pin, holds core
// - only power-on forces monitor enable
// - monitor resets only if on and selected
// - unsettled monitor may still cause reset
// - no power-on delay after monitor reset
// - control bit 6 shows live monitor
// - control bits 5..0 read zero
// - low reset pin resets the device
// - pin reset sets cause bit 0
// - stuck clock past timeout causes reset
// - cause bit 2 flags clock loss
// - cause bit 2 write enables detector
// - clock loss, comparator leave pin alone
// - cause bit 5 write selects comparator
// - selected comparator low causes reset
// - cause bit 5 flags comparator reset
// - monitor reset leaves data memory alone
// - power-on or monitor exit sets bit 1
module rsm_top #(
  parameter logic [rsm_pkg::CNT_W-1:0] POR_DELAY =
    rsm_pkg::CNT_W'(rsm_pkg::POR_DELAY_CYC),
  parameter logic [rsm_pkg::CNT_W-1:0] MCD_TIMEOUT =
    rsm_pkg::CNT_W'(rsm_pkg::MCD_TIMEOUT_CYC)
) (
  // clock and power-on reset
  input wire logic sys_clk,
  input wire logic reset,
  // apb slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [rsm_pkg::ADDR_W-1:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // supply monitor
  input wire logic supplyOk,
  output logic monitorOn,
  // comparator 0 output and watched clock
  input wire logic cmpOut,
  input wire logic monClk,
  // open-drain reset pin, active low
  input wire logic rstPinIn,
  output logic rstPinOut,
  output logic rstPinOe,
  // core reset
  output logic sysReset
);
  import rsm_pkg::*;

  logic [SYNC_W-1:0] syncA_r;
  logic [SYNC_W-1:0] syncB_r;
  logic [2:0] oeHist_r;
  logic supplyOkS;
  logic vdmReq;
  logic pinReq;
  logic mcdReq;
  logic cmpReq;
  logic anyReq;
  rsm_state_t state_r;
  rsm_state_t stNxt;
  rsm_cause_t cause_r;
  logic [CNT_W-1:0] cnt_r;
  logic holdDone;
  logic enterHold;
  logic exitHold;
  logic exitPor;
  logic sysReset_r;
  logic pinDrive_r;
  logic monOn_r;
  logic vdmSel_r;
  logic mcdEn_r;
  logic cmpSel_r;
  logic pinFlag_r;
  logic porFlag_r;
  logic mcdFlag_r;
  logic cmpFlag_r;
  logic [31:0] prdata_r;
  logic hitSmc;
  logic hitRcr;
  logic wrSmc;
  logic wrRcr;

  rsm_mcd_if mcdLink ();

  ////////////////////////////////////////////////////////////////////////
  // two-flop synchronisers for every asynchronous input
  always_ff @(posedge sys_clk or posedge reset) begin
    if (reset) begin
      syncA_r <= '0;
      syncB_r <= '0;
    end else begin
      syncA_r <= {monClk, cmpOut, rstPinIn, supplyOk};
      syncB_r <= syncA_r;
    end
  end

  // pin reads back low while we drive it, so mask it a while after
  always_ff @(posedge sys_clk or posedge reset) begin
    if (reset) begin
      oeHist_r <= 3'h7;
    end else begin
      oeHist_r <= {oeHist_r[1:0], pinDrive_r};
    end
  end

  assign supplyOkS = syncB_r[SI_SUPPLY];

  // monitor output used live, settled or not
  assign vdmReq = monOn_r && vdmSel_r && !supplyOkS;
  assign pinReq = !syncB_r[SI_PIN] && !pinDrive_r &&
    !(|oeHist_r);
  assign mcdReq = mcdLink.missing && mcdEn_r;
  assign cmpReq = cmpSel_r && !syncB_r[SI_CMP];
  assign anyReq = vdmReq || pinReq || mcdReq || cmpReq;

  ////////////////////////////////////////////////////////////////////////
  // missing clock watcher
  assign mcdLink.enable = mcdEn_r && (state_r == RSM_ST_RUN);
  assign mcdLink.clkLevel = syncB_r[SI_CLK];

  rsm_clock_watch #(
    .TIMEOUT_CYC(MCD_TIMEOUT)
  ) u_watch (
    .sys_clk(sys_clk),
    .reset(reset),
    .mcd(mcdLink.watch)
  );

  ////////////////////////////////////////////////////////////////////////
  // monitor resets skip the minimum hold so release follows the supply
  assign holdDone = (cause_r == RSM_CAUSE_VDM) ||
    (cnt_r == HOLD_MIN_CYC);

  // sequencer next state
  always_comb begin
    stNxt = state_r;
    case (state_r)
      RSM_ST_POR: begin
        if (supplyOkS && cnt_r == POR_DELAY) begin
          stNxt = RSM_ST_RUN;
        end
      end
      RSM_ST_RUN: begin
        if (anyReq) begin
          stNxt = RSM_ST_HOLD;
        end
      end
      RSM_ST_HOLD: begin
        if (!anyReq && holdDone) begin
          stNxt = RSM_ST_RUN;
        end
      end
      default: begin
        stNxt = RSM_ST_POR;
      end
    endcase
  end

  assign enterHold = (state_r == RSM_ST_RUN) && anyReq;
  assign exitHold = (state_r == RSM_ST_HOLD) && (stNxt == RSM_ST_RUN);
  assign exitPor = (state_r == RSM_ST_POR) && (stNxt == RSM_ST_RUN);

  // state and registered reset outputs
  always_ff @(posedge sys_clk or posedge reset) begin
    if (reset) begin
      state_r <= RSM_ST_POR;
      sysReset_r <= 1'h1;
      pinDrive_r <= 1'h1;
    end else begin
      state_r <= stNxt;
      sysReset_r <= stNxt != RSM_ST_RUN;
      // only power-on and supply faults pull the pin
      pinDrive_r <= (stNxt == RSM_ST_POR) ||
        ((stNxt == RSM_ST_HOLD) && (enterHold ?
        vdmReq : (cause_r == RSM_CAUSE_VDM)));
    end
  end

  // cause captured at entry, supply fault has top priority
  always_ff @(posedge sys_clk or posedge reset) begin
    if (reset) begin
      cause_r <= RSM_CAUSE_VDM;
    end else if (enterHold) begin
      if (vdmReq) begin
        cause_r <= RSM_CAUSE_VDM;
      end else if (pinReq) begin
        cause_r <= RSM_CAUSE_PIN;
      end else if (mcdReq) begin
        cause_r <= RSM_CAUSE_MCD;
      end else begin
        cause_r <= RSM_CAUSE_CMP;
      end
    end
  end

  // power-on delay counter and minimum hold counter
  always_ff @(posedge sys_clk or posedge reset) begin
    if (reset) begin
      cnt_r <= '0;
    end else if (state_r == RSM_ST_POR) begin
      if (!supplyOkS) begin
        cnt_r <= '0;
      end else if (cnt_r != POR_DELAY) begin
        cnt_r <= cnt_r + CNT_W'(1);
      end
    end else if (state_r == RSM_ST_HOLD) begin
      if (cnt_r != HOLD_MIN_CYC) begin
        cnt_r <= cnt_r + CNT_W'(1);
      end
    end else begin
      cnt_r <= '0;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // cause flags written on leaving reset
  always_ff @(posedge sys_clk or posedge reset) begin
    if (reset) begin
      pinFlag_r <= 1'h0;
      porFlag_r <= 1'h0;
      mcdFlag_r <= 1'h0;
      cmpFlag_r <= 1'h0;
    end else if (exitPor) begin
      porFlag_r <= 1'h1;
      pinFlag_r <= 1'h0;
      mcdFlag_r <= 1'h0;
      cmpFlag_r <= 1'h0;
    end else if (exitHold) begin
      // other flags keep stale values after a monitor reset
      porFlag_r <= cause_r == RSM_CAUSE_VDM;
      if (cause_r != RSM_CAUSE_VDM) begin
        pinFlag_r <= cause_r == RSM_CAUSE_PIN;
        mcdFlag_r <= cause_r == RSM_CAUSE_MCD;
        cmpFlag_r <= cause_r == RSM_CAUSE_CMP;
      end
    end
  end

  // monitor enable: power-on value only, untouched by system resets
  always_ff @(posedge sys_clk or posedge reset) begin
    if (reset) begin
      monOn_r <= MON_ON_RST;
      vdmSel_r <= VDM_SEL_RST;
    end else begin
      if (wrSmc) begin
        monOn_r <= pwdata[SMC_ON_BIT];
      end
      if (wrRcr) begin
        vdmSel_r <= pwdata[RCR_POR_BIT];
      end
    end
  end

  // detector and comparator selects drop on any reset entry
  always_ff @(posedge sys_clk or posedge reset) begin
    if (reset) begin
      mcdEn_r <= MCD_EN_RST;
      cmpSel_r <= CMP_SEL_RST;
    end else if (enterHold) begin
      mcdEn_r <= MCD_EN_RST;
      cmpSel_r <= CMP_SEL_RST;
    end else if (wrRcr) begin
      mcdEn_r <= pwdata[RCR_MCD_BIT];
      cmpSel_r <= pwdata[RCR_CMP_BIT];
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // apb decode, zero wait state
  assign hitSmc = paddr == ADDR_SMC;
  assign hitRcr = paddr == ADDR_RCR;
  assign pready = 1'h1;
  assign pslverr = psel && penable && !(hitSmc || hitRcr);
  assign wrSmc = psel && penable && pwrite && hitSmc;
  assign wrRcr = psel && penable && pwrite && hitRcr;

  // read data captured in the setup cycle
  always_ff @(posedge sys_clk or posedge reset) begin
    if (reset) begin
      prdata_r <= 32'h0000_0000;
    end else if (psel && !penable) begin
      prdata_r <= 32'h0000_0000;
      if (hitSmc) begin
        prdata_r[SMC_ON_BIT] <= monOn_r;
        prdata_r[SMC_STAT_BIT] <= supplyOkS;
      end else if (hitRcr) begin
        prdata_r[RCR_PIN_BIT] <= pinFlag_r;
        prdata_r[RCR_POR_BIT] <= porFlag_r;
        prdata_r[RCR_MCD_BIT] <= mcdFlag_r;
        prdata_r[RCR_CMP_BIT] <= cmpFlag_r;
      end
    end
  end

  // core reset only; no memory clear is issued, so contents survive
  assign sysReset = sysReset_r;
  assign prdata = prdata_r;
  assign monitorOn = monOn_r;
  assign rstPinOut = 1'h0;
  assign rstPinOe = pinDrive_r;

  ////////////////////////////////////////////////////////////////////////
  // checks
  default clocking cb @(posedge sys_clk);
  endclocking
  default disable iff (reset);

  // fault seen in run and still present once the hold has begun
  sequence s_vdm_fault;
    state_r == RSM_ST_RUN && vdmReq ##1 vdmReq;
  endsequence

  sequence s_hold_exit;
    state_r == RSM_ST_HOLD && !anyReq && holdDone;
  endsequence

  sequence s_smc_setup;
    psel && !penable && hitSmc;
  endsequence

  a_vdm_holds: assert property (
    s_vdm_fault |-> (sysReset_r && rstPinOe) [*2])
    else $error("supply fault did not hold reset and pin");

  a_vdm_release: assert property (
    s_hold_exit and cause_r == RSM_CAUSE_VDM |=> !sysReset_r)
    else $error("release delayed after supply recovered");

  a_mon_kept: assert property (
    state_r != RSM_ST_RUN && !wrSmc |=> $stable(monOn_r))
    else $error("monitor enable changed by a reset");

  a_vdm_gate: assert property (
    state_r == RSM_ST_RUN && !(monOn_r && vdmSel_r) && !pinReq &&
    !mcdReq && !cmpReq |=> !sysReset_r)
    else $error("unselected monitor raised reset");

  a_stat_live: assert property (
    s_smc_setup |=> prdata[SMC_STAT_BIT] == $past(supplyOkS))
    else $error("status bit does not follow monitor");

  a_smc_low: assert property (
    s_smc_setup |=> prdata[5:0] == 6'h00)
    else $error("low control bits not zero");

  a_pin_reset: assert property (
    state_r == RSM_ST_RUN && pinReq && !vdmReq |=>
    sysReset_r && !rstPinOe)
    else $error("pin request not followed by reset");

  a_pin_flag: assert property (
    s_hold_exit and cause_r == RSM_CAUSE_PIN |=>
    pinFlag_r && !porFlag_r && !mcdFlag_r && !cmpFlag_r)
    else $error("pin cause flag wrong");

  a_mcd_flag: assert property (
    s_hold_exit and cause_r == RSM_CAUSE_MCD |=> mcdFlag_r && !pinFlag_r)
    else $error("clock loss flag wrong");

  a_cmp_flag: assert property (
    s_hold_exit and cause_r == RSM_CAUSE_CMP |=> cmpFlag_r && !mcdFlag_r)
    else $error("comparator flag wrong");

  a_mcd_reset: assert property (
    state_r == RSM_ST_RUN && mcdReq |=> sysReset_r)
    else $error("clock loss did not reset");

  a_quiet_pin: assert property (
    state_r == RSM_ST_HOLD && (cause_r == RSM_CAUSE_MCD ||
    cause_r == RSM_CAUSE_CMP) |-> !rstPinOe)
    else $error("internal reset drove the pin");

  a_mcd_write: assert property (
    wrRcr && !enterHold |=> mcdEn_r == $past(pwdata[RCR_MCD_BIT]))
    else $error("detector enable not written");

  a_cmp_reset: assert property (
    state_r == RSM_ST_RUN && cmpReq |=> sysReset_r ##1 !cmpSel_r)
    else $error("comparator request not followed by reset");

  a_por_flag: assert property (
    exitPor |=> porFlag_r && !pinFlag_r)
    else $error("power-on flag not set");
endmodule : rsm_top

// ---- pkg/rsm_mcd_if.sv ----
// Purpose: link between the top and the missing clock watcher
// Assumes: one clock domain, sys_clk
// Notes: clkLevel is already synchronised by the top
interface rsm_mcd_if;
  logic enable;
  logic clkLevel;
  logic missing;
  modport ctrl(output enable, output clkLevel, input missing);
  modport watch(input enable, input clkLevel, output missing);
endinterface : rsm_mcd_if

// ---- pkg/rsm_pkg.sv ----
// Purpose: shared constants and types of the reset source monitor
// Assumes: 125 MHz sys_clk, registers reached over APB
// Notes: register data is 8 bits in the low lane of a 32-bit word
package rsm_pkg;
  // clock and timing
  localparam int CLK_PERIOD_NS = 8;
  localparam int POR_DELAY_NS = 300_000;
  localparam int MCD_TIMEOUT_NS = 100_000;
  localparam int HOLD_MIN_NS = 32;
  localparam int POR_DELAY_CYC =
    (POR_DELAY_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int MCD_TIMEOUT_CYC =
    (MCD_TIMEOUT_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int CNT_W = 16;
  localparam logic [CNT_W-1:0] HOLD_MIN_CYC =
    CNT_W'((HOLD_MIN_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
  //////////////////////////////////////////////////////////////////////
  // register indices, byte address is four times the index
  localparam int ADDR_W = 12;
  localparam logic [9:0] IDX_SMC = 10'h0ff;
  localparam logic [9:0] IDX_RCR = 10'h0ef;
  localparam logic [ADDR_W-1:0] ADDR_SMC = {IDX_SMC, 2'h0};
  localparam logic [ADDR_W-1:0] ADDR_RCR = {IDX_RCR, 2'h0};
  // field positions
  localparam int SMC_ON_BIT = 7;
  localparam int SMC_STAT_BIT = 6;
  localparam int RCR_PIN_BIT = 0;
  localparam int RCR_POR_BIT = 1;
  localparam int RCR_MCD_BIT = 2;
  localparam int RCR_CMP_BIT = 5;
  // reset values after power-on
  localparam logic MON_ON_RST = 1'h1;
  localparam logic VDM_SEL_RST = 1'h1;
  localparam logic MCD_EN_RST = 1'h0;
  localparam logic CMP_SEL_RST = 1'h0;
  // synchroniser lanes
  localparam int SYNC_W = 4;
  localparam int SI_SUPPLY = 0;
  localparam int SI_PIN = 1;
  localparam int SI_CMP = 2;
  localparam int SI_CLK = 3;
  //////////////////////////////////////////////////////////////////////
  typedef enum logic [1:0] {
    RSM_ST_POR = 2'h0,
    RSM_ST_RUN = 2'h1,
    RSM_ST_HOLD = 2'h3
  } rsm_state_t;
  typedef enum logic [1:0] {
    RSM_CAUSE_VDM = 2'h0,
    RSM_CAUSE_PIN = 2'h1,
    RSM_CAUSE_MCD = 2'h2,
    RSM_CAUSE_CMP = 2'h3
  } rsm_cause_t;
endpackage : rsm_pkg

// ---- tb/reset_source_monitor_tb.sv ----
// Purpose: self-checking bench for the reset source monitor
// Assumes: short power-on delay and clock-loss timeout parameters
// Notes: registers reached by an apb master task, zero or more waits
module reset_source_monitor_tb;
  timeunit 1ns;
  timeprecision 100ps;
  import rsm_pkg::*;
  localparam logic [CNT_W-1:0] POR_CYC = 16'h0028;
  localparam logic [CNT_W-1:0] MCD_CYC = 16'h0008;
  logic sys_clk = 1'b0;
  logic reset = 1'b1;
  logic psel, penable, pwrite, pready, pslverr;
  logic [ADDR_W-1:0] paddr;
  logic [31:0] pwdata, prdata, q;
  logic supplyOk, monitorOn, cmpOut, monClk, rstPinIn, rstPinOut;
  logic rstPinOe, sysReset, e, pullLow, supplyLow, cmpLow, clkStop;
  int n_mismatch = 0;
  int check_count = 0;
  int n;
  always #4 sys_clk = ~sys_clk;
  rsm_top #(.POR_DELAY(POR_CYC), .MCD_TIMEOUT(MCD_CYC)) dut_u (
    .sys_clk(sys_clk), .reset(reset), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .supplyOk(supplyOk),
    .monitorOn(monitorOn), .cmpOut(cmpOut), .monClk(monClk),
    .rstPinIn(rstPinIn), .rstPinOut(rstPinOut), .rstPinOe(rstPinOe),
    .sysReset(sysReset));
  rsm_ext_model ext_u (
    .sys_clk(sys_clk), .monitorOn(monitorOn), .rstPinOut(rstPinOut),
    .rstPinOe(rstPinOe), .supplyOk(supplyOk), .rstPinIn(rstPinIn),
    .cmpOut(cmpOut), .monClk(monClk), .pullLow(pullLow),
    .supplyLow(supplyLow), .cmpLow(cmpLow), .clkStop(clkStop));
  ////////////////////////////////////////////////////////////////////////
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    check_count++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("ERROR t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask : chk
  task automatic test_done;
    $display("checks %0d mismatches %0d", check_count, n_mismatch);
    if (n_mismatch == 0 && check_count > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask : test_done
  // one apb transfer; holds the request until pready is seen
  task automatic apb(input logic wr, input logic [ADDR_W-1:0] a,
                     input logic [31:0] d);
    @(posedge sys_clk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge sys_clk);
    penable <= 1'b1;
    // no local limit: only the watchdog ends a stuck wait
    do begin
      @(posedge sys_clk);
    end while (pready !== 1'b1);
    q = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge sys_clk); // let the write land before looking
  endtask : apb
  // bounded wait for the core reset level
  task automatic waitSys(input logic v, input int lim);
    n = 0;
    while (sysReset !== v && n < lim) begin
      @(posedge sys_clk);
      n++;
    end
  endtask : waitSys
  function automatic logic [7:0] expCause(input int src);
    return (src == 0) ? 8'h01 : (src == 1) ? 8'h04 : 8'h20;
  endfunction : expCause
  // select one source, trigger it, check flags after release
  task automatic fireSource(input int src);
    logic [7:0] w;
    w = 8'h02 | (src == 1 ? 8'h04 : 8'h00) | (src == 2 ? 8'h20 : 8'h00);
    apb(1'b1, ADDR_RCR, {24'h00_0000, w});
    repeat (20) @(posedge sys_clk);
    chk(sysReset, 1'b0);
    pullLow <= (src == 0);
    clkStop <= (src == 1);
    cmpLow <= (src == 2);
    waitSys(1'b1, 40);
    chk(sysReset, 1'b1);
    if (src != 0) chk(rstPinOe, 1'b0);
    repeat ($urandom_range(9, 2)) @(posedge sys_clk);
    pullLow <= 1'b0;
    clkStop <= 1'b0;
    cmpLow <= 1'b0;
    waitSys(1'b0, 40);
    chk(sysReset, 1'b0);
    apb(1'b0, ADDR_RCR, 32'h0000_0000);
    chk(q, {24'h00_0000, expCause(src)});
    $display("test source %0d done", src);
  endtask : fireSource
  ////////////////////////////////////////////////////////////////////////
  // hang guard, well beyond the several hundred cycles the run needs
  initial begin
    #100_000;
    n_mismatch++;
    $display("watchdog expired");
    test_done();
  end
  initial begin
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = '0;
    pwdata = '0;
    pullLow = 1'b0;
    supplyLow = 1'b0;
    cmpLow = 1'b0;
    clkStop = 1'b0;
    void'($urandom(94381));
    repeat (5) @(posedge sys_clk);
    reset <= 1'b0;
    waitSys(1'b0, 200);
    chk(rstPinOe, 1'b0);
    apb(1'b0, ADDR_RCR, 32'h0000_0000);
    chk(q[RCR_POR_BIT], 1'b1);
    chk(monitorOn, 1'b1);
    apb(1'b1, ADDR_SMC, {24'h00_0000, 2'b10, 6'($urandom)});
    apb(1'b0, ADDR_SMC, 32'h0000_0000);
    chk(q, 32'h0000_00C0);
    apb(1'b0, 12'h000, 32'h0000_0000); // unmapped place is refused
    chk(q, 32'h0000_0000);
    chk(32'(e), 32'h0000_0001);
    $display("test power-on and map done");
    // sources enabled and then written off must stay quiet
    apb(1'b1, ADDR_RCR, 32'h0000_0026);
    apb(1'b1, ADDR_RCR, 32'h0000_0002);
    cmpLow <= 1'b1;
    clkStop <= 1'b1;
    repeat (30) @(posedge sys_clk);
    chk(sysReset, 1'b0);
    cmpLow <= 1'b0;
    clkStop <= 1'b0;
    for (int i = 0; i < 7; i++) fireSource(i < 3 ? i : $urandom_range(2));
    // monitor switched off: no reset, and survives other resets
    apb(1'b1, ADDR_SMC, 32'h0000_0000);
    chk(monitorOn, 1'b0);
    supplyLow <= 1'b1;
    repeat (20) @(posedge sys_clk);
    chk(sysReset, 1'b0);
    supplyLow <= 1'b0;
    fireSource(0);
    chk(monitorOn, 1'b0);
    apb(1'b1, ADDR_RCR, 32'h0000_0000);
    apb(1'b1, ADDR_SMC, 32'h0000_0080);
    repeat (10) @(posedge sys_clk);
    supplyLow <= 1'b1;
    repeat (20) @(posedge sys_clk);
    chk(sysReset, 1'b0);
    supplyLow <= 1'b0;
    repeat (5) @(posedge sys_clk);
    apb(1'b1, ADDR_RCR, 32'h0000_0002);
    // low supply: pin driven, status bit low, quick release
    supplyLow <= 1'b1;
    waitSys(1'b1, 20);
    chk({sysReset, rstPinOe}, 2'b11);
    apb(1'b0, ADDR_SMC, 32'h0000_0000);
    chk(q, 32'h0000_0080);
    supplyLow <= 1'b0;
    waitSys(1'b0, 60);
    chk(32'(n < int'(POR_CYC)), 32'h0000_0001);
    apb(1'b0, ADDR_RCR, 32'h0000_0000);
    chk(q[RCR_POR_BIT], 1'b1);
    $display("test supply monitor done");
    // selected monitor switched on again: chatter may reset at once
    apb(1'b1, ADDR_SMC, 32'h0000_0000);
    apb(1'b1, ADDR_SMC, 32'h0000_0080);
    waitSys(1'b1, 10);
    chk(sysReset, 1'b1);
    waitSys(1'b0, 40);
    repeat (10) @(posedge sys_clk);
    chk(sysReset, 1'b0);
    $display("test early select done");
    // power-on forces the monitor back on
    apb(1'b1, ADDR_SMC, 32'h0000_0000);
    reset <= 1'b1;
    repeat (5) @(posedge sys_clk);
    reset <= 1'b0;
    waitSys(1'b0, 200);
    chk(monitorOn, 1'b1);
    $display("test second power-on done");
    test_done();
  end
endmodule : reset_source_monitor_tb

// ---- tb/rsm_ext_model.sv ----
// Purpose: far side of the reset monitor: pin, supply monitor, comparator
// Assumes: reset pin has a pull-up; watched clock runs unless stopped
// Notes: monitor output chatters until it has been on for SETTLE cycles
module rsm_ext_model #(
  parameter int SETTLE = 4
) (
  // clock
  input wire logic sys_clk,
  // device side
  input wire logic monitorOn,
  input wire logic rstPinOut,
  input wire logic rstPinOe,
  output logic supplyOk,
  output logic rstPinIn,
  output logic cmpOut,
  output logic monClk,
  // bench controls
  input wire logic pullLow,
  input wire logic supplyLow,
  input wire logic cmpLow,
  input wire logic clkStop
);
  timeunit 1ns;
  timeprecision 100ps;
  int settleCnt = 0;
  logic chatter = 1'b0;
  ////////////////////////////////////////////////////////////////////////
  // unsettled monitor toggles, so an early select can still reset
  always @(posedge sys_clk) begin
    chatter <= ~chatter;
    if (monitorOn !== 1'b1) begin
      settleCnt <= 0;
    end else if (settleCnt < SETTLE) begin
      settleCnt <= settleCnt + 1;
    end
  end
  assign supplyOk = (settleCnt >= SETTLE) ? !supplyLow : chatter;
  // open-drain pin: anyone pulling wins, else pull-up
  assign rstPinIn = !((rstPinOe && !rstPinOut) || pullLow);
  assign cmpOut = !cmpLow; // low output asks for reset
  // watched clock, unrelated in phase; stands still when stopped
  initial begin
    monClk = 1'b0;
    forever begin
      #6;
      if (!clkStop) begin
        monClk = ~monClk;
      end
    end
  end
endmodule : rsm_ext_model
